// [sfrpe_pkg.sv]
// constants, types and helpers shared by the serial flash instruction engine
// assumes a 2 MB array, 256-byte pages, 4 KB sectors and 64 KB blocks
package sfrpe_pkg;

    // array geometry
    localparam int ADDR_W      = 21;
    localparam int MEM_BYTES   = 1 << ADDR_W;
    localparam int PAGE_BYTES  = 256;
    localparam logic [15:0] PAGE_LAST   = 16'h00FF;
    localparam logic [15:0] SECTOR_LAST = 16'h0FFF;
    localparam logic [15:0] BLOCK_LAST  = 16'hFFFF;
    localparam logic [4:0]  BLOCK_TOP   = 5'h1F;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // fixed read opcodes
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO   = 8'hBB;

    // rising-edge counts within a frame
    localparam logic [5:0] CNT_FIRST     = 6'h01;
    localparam logic [5:0] CNT_OPCODE    = 6'h08;
    localparam logic [5:0] CNT_DIO_ADDR  = 6'h14;
    localparam logic [5:0] CNT_DIO_DUMMY = 6'h18;
    localparam logic [5:0] CNT_ADDR_END  = 6'h20;
    localparam logic [5:0] CNT_DUMMY_END = 6'h28;
    localparam logic [5:0] CNT_MAX       = 6'h3F;
    localparam logic [2:0] BITPOS_BYTE   = 3'h0;
    localparam logic [2:0] LEFT_SINGLE   = 3'h7;
    localparam logic [2:0] LEFT_DUAL     = 3'h3;
    localparam logic [2:0] PROTECT_ALL   = 3'h6;

    // self-timed cycle durations, typical figures
    localparam longint CLK_PERIOD_PS = 4000;
    localparam longint T_PP_US       = 2000;
    localparam longint T_SE_MS       = 80;
    localparam longint T_BE_MS       = 500;
    localparam int PP_CYCLES_DEF = int'((T_PP_US * 64'd1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int SE_CYCLES_DEF = int'((T_SE_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int BE_CYCLES_DEF = int'((T_BE_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // what the link holds at the end of a frame
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] addr;
        logic [5:0]  cnt;
        logic [2:0]  bitpos;
    } sfrpe_frame_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_WAIT} sfrpe_state_t;

    // top 2^(bp-1) of the 32 blocks are read-only; 6 and 7 cover all
    function automatic logic sfrpe_protected(input logic [ADDR_W-1:0] addr, input logic [2:0] bp);
        logic [5:0] span;
        span = 6'h00;
        if (bp >= PROTECT_ALL) begin
            return 1'b1;
        end
        if (bp == 3'h0) begin
            return 1'b0;
        end
        span = 6'(6'h01 << (bp - 3'h1));
        return ({1'b0, addr[ADDR_W-1:16]} > (6'({1'b0, BLOCK_TOP}) - span));
    endfunction : sfrpe_protected

endpackage : sfrpe_pkg

// [sfrpe_top.sv]
// serial flash instruction engine: fast reads, page program, sector and block erase
// assumes SCLK idles low between frames (mode 0) and stands still while CS_N is high
// Summary of operation
// - fast read: opcode, three address bytes, dummy byte, all sampled on rising SCLK
// - fast read data leaves on the single output, changing on falling SCLK
// - read address steps per byte and wraps from the top to zero
// - raising select ends a read and releases the outputs at once
// - reads arriving during a program or erase cycle are rejected, cycle untouched
// - dual-output read: same header, then two data bits per clock
// - dual-output read: eight dummy clocks after the address, inputs ignored
// - dual I/O read: address in two bits per clock, four ignored dummy clocks
// - the three highest address bits are ignored everywhere
// - page program only clears bits and needs the write-enable latch set
// - program data passing the page end wraps to the page start
// - only the last 256 bytes are kept; unsent bytes stay untouched
// - select must rise on a data byte boundary or the program is dropped
// - select rise starts the timed program, flag set, latch cleared before end
// - a program aimed at a protected page is not executed
// - sector erase sets the sector to ones and needs the latch set
// - sector erase runs only on a clean select rise, flag set, latch cleared
// - block erase sets the block to ones, timed cycle with flag set
// - erases aimed at protected memory are rejected, memory unchanged
// - progress flag is one during the timed cycle, zero after, always readable
`timescale 1ns/1ps
module sfrpe_top
    import sfrpe_pkg::*;
#(
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_PAGE_WRITE   = 8'h02,
    parameter logic [7:0] OP_SECTOR_CLEAR = 8'h20,
    parameter logic [7:0] OP_BLOCK_CLEAR  = 8'hD8,
    parameter int         PP_CYCLES       = PP_CYCLES_DEF,
    parameter int         SE_CYCLES       = SE_CYCLES_DEF,
    parameter int         BE_CYCLES       = BE_CYCLES_DEF
) (
    // core clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    // serial link
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       DIO_IN,
    output logic            DIO_OUT,
    output logic            DIO_OE_N,
    input  wire logic       DO_IN,
    output logic            DO_OUT,
    output logic            DO_OE_N,
    // protection and status
    input  wire logic [2:0] PROTECT_FIELD,
    output logic            CYCLE_IN_PROGRESS_FLAG,
    output logic            WRITE_ENABLE_LATCH
);

    // shared array: written by the core, read by the link only while idle
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] page_buf [0:PAGE_BYTES-1];

    // link-domain state
    logic                    fresh;
    sfrpe_frame_t            frm;
    logic [6:0]              data_shift;
    logic [7:0]              wr_ptr;
    logic [PAGE_BYTES-1:0]   wr_mask;
    logic                    read_go;
    logic                    frame_tog;
    logic                    busy_l1;
    logic                    busy_l2;
    logic                    started;
    logic [2:0]              out_left;
    logic [7:0]              out_shift;
    logic [ADDR_W-1:0]       rd_addr;

    // a raised select sets the frame start flag and clears the output drivers at once
    wire frame_rst = RESET | CS_N;

    // next values on each rising SCLK
    wire [5:0] next_cnt    = fresh ? CNT_FIRST : ((frm.cnt == CNT_MAX) ? CNT_MAX : 6'(frm.cnt + 6'h01));
    wire [2:0] next_bitpos = fresh ? 3'h1 : 3'(frm.bitpos + 3'h1);
    wire       in_opcode   = fresh | (frm.cnt < CNT_OPCODE);
    wire       is_dual_io  = (frm.op == OP_DUAL_IO);
    wire       is_read     = (frm.op == OP_FAST_READ) | (frm.op == OP_DUAL_OUT) | is_dual_io;
    wire       addr_single = !in_opcode & !is_dual_io & (frm.cnt < CNT_ADDR_END);
    wire       addr_dual   = !in_opcode & is_dual_io & (frm.cnt < CNT_DIO_ADDR);
    wire [7:0] next_op     = fresh ? {7'h00, DIO_IN} : (in_opcode ? {frm.op[6:0], DIO_IN} : frm.op);
    wire [23:0] next_addr  = addr_dual ? {frm.addr[21:0], DO_IN, DIO_IN} :
                             (addr_single ? {frm.addr[22:0], DIO_IN} : frm.addr);
    // dummy clocks carry nothing; only the count matters
    wire [5:0] dummy_end   = is_dual_io ? CNT_DIO_DUMMY : CNT_DUMMY_END;
    // a frame during a running cycle must not touch the page buffer
    wire       pp_data     = !fresh & (frm.op == OP_PAGE_WRITE) & (frm.cnt >= CNT_ADDR_END) & !busy_l2;
    wire       pp_byte     = pp_data & (next_bitpos == BITPOS_BYTE);
    wire       addr_done   = !fresh & (next_cnt == CNT_ADDR_END) & (frm.cnt != CNT_ADDR_END);

    // frame start flag, set while deselected
    always_ff @(posedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // opcode, address and count capture
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            frm        <= '0;
            data_shift <= 7'h00;
            frame_tog  <= 1'b0;
        end else begin
            frm.op     <= next_op;
            frm.addr   <= next_addr;
            frm.cnt    <= next_cnt;
            frm.bitpos <= next_bitpos;
            data_shift <= {data_shift[5:0], DIO_IN};
            frame_tog  <= frame_tog ^ fresh;   // tells the core a frame had clocks
        end
    end

    // busy level into the link domain; settled long before the opcode ends
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            busy_l1 <= 1'b0;
            busy_l2 <= 1'b0;
        end else begin
            busy_l1 <= CYCLE_IN_PROGRESS_FLAG;
            busy_l2 <= busy_l1;
        end
    end

    // read start after the last dummy clock
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            read_go <= 1'b0;
        end else if (fresh) begin
            read_go <= 1'b0;
        // refuse reads while a cycle runs
        end else if (is_read & (next_cnt == dummy_end) & !busy_l2) begin
            read_go <= 1'b1;
        end
    end

    // program buffer pointer and written-byte mask
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            wr_ptr  <= 8'h00;
            wr_mask <= '0;
        end else if (addr_done & (frm.op == OP_PAGE_WRITE) & !busy_l2) begin
            // start at the addressed byte of the page
            wr_ptr  <= next_addr[7:0];
            wr_mask <= '0;
        end else if (pp_byte) begin
            // pointer wraps in the page; later bytes overwrite
            wr_ptr          <= 8'(wr_ptr + 8'h01);
            wr_mask[wr_ptr] <= 1'b1;
        end
    end

    // program data bytes, no reset on a memory
    always_ff @(posedge SCLK) begin
        if (pp_byte) begin
            page_buf[wr_ptr] <= {data_shift, DIO_IN};
        end
    end

    // output byte source and dual selection
    wire              out_dual  = (frm.op == OP_DUAL_OUT) | is_dual_io;
    wire              need_load = !started | (out_left == 3'h0);
    wire [ADDR_W-1:0] cur_addr  = started ? rd_addr : frm.addr[ADDR_W-1:0];
    wire [7:0]        cur_byte  = mem[cur_addr];

    // data out on falling SCLK
    always_ff @(negedge SCLK or posedge frame_rst) begin
        if (frame_rst) begin
            // release outputs as soon as select rises
            DO_OE_N   <= 1'b1;
            DIO_OE_N  <= 1'b1;
            DO_OUT    <= 1'b0;
            DIO_OUT   <= 1'b0;
            started   <= 1'b0;
            out_left  <= 3'h0;
            out_shift <= 8'h00;
            rd_addr   <= '0;
        end else if (read_go) begin
            started  <= 1'b1;
            DO_OE_N  <= 1'b0;
            // second data line driven only in dual modes
            DIO_OE_N <= !out_dual;
            if (need_load) begin
                // step and wrap the read address
                rd_addr <= ADDR_W'(cur_addr + 1'b1);
                DO_OUT  <= cur_byte[7];
                DIO_OUT <= cur_byte[6];
                if (out_dual) begin
                    out_shift <= {cur_byte[5:0], 2'b00};
                    out_left  <= LEFT_DUAL;
                end else begin
                    out_shift <= {cur_byte[6:0], 1'b0};
                    out_left  <= LEFT_SINGLE;
                end
            end else begin
                DO_OUT   <= out_shift[7];
                DIO_OUT  <= out_shift[6];
                out_left <= 3'(out_left - 3'h1);
                if (out_dual) begin
                    out_shift <= {out_shift[5:0], 2'b00};
                end else begin
                    out_shift <= {out_shift[6:0], 1'b0};
                end
            end
        end
    end

    // core-domain synchronisers for select, frame token and protect pins
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_prev;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_seen;
    logic [2:0] prot_s1;
    logic [2:0] prot_s2;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_prev <= 1'b1;
            tog_s1  <= 1'b0;
            tog_s2  <= 1'b0;
            prot_s1 <= 3'h0;
            prot_s2 <= 3'h0;
        end else begin
            cs_s1   <= CS_N;
            cs_s2   <= cs_s1;
            cs_prev <= cs_s2;
            tog_s1  <= frame_tog;
            tog_s2  <= tog_s1;
            prot_s1 <= PROTECT_FIELD;
            prot_s2 <= prot_s1;
        end
    end

    // frame end; link fields stand still while select is high
    wire cs_rise    = cs_s2 & !cs_prev;
    wire frame_done = cs_rise & (tog_s2 != tog_seen);
    wire [ADDR_W-1:0] frm_addr = frm.addr[ADDR_W-1:0];
    wire frm_prot = sfrpe_protected(frm_addr, prot_s2);

    // decoded commands at select rise
    wire cmd_write_enable_cmd  = (frm.op == OP_WRITE_ENABLE) & (frm.cnt == CNT_OPCODE);
    // byte boundary after at least one data byte
    wire pp_ok     = (frm.op == OP_PAGE_WRITE) & (frm.cnt >= CNT_DUMMY_END) & (frm.bitpos == BITPOS_BYTE);
    // erases end right after the address
    wire erase_len = (frm.cnt == CNT_ADDR_END) & (frm.bitpos == BITPOS_BYTE);
    wire se_ok     = (frm.op == OP_SECTOR_CLEAR) & erase_len;
    wire be_ok     = (frm.op == OP_BLOCK_CLEAR) & erase_len;
    wire may_write = WRITE_ENABLE_LATCH & !frm_prot;
    wire start_pp  = frame_done & !CYCLE_IN_PROGRESS_FLAG & pp_ok & may_write;
    wire start_er  = frame_done & !CYCLE_IN_PROGRESS_FLAG & (se_ok | be_ok) & may_write;

    // self-timed engine state
    sfrpe_state_t      state;
    logic              is_prog;
    logic [ADDR_W-1:0] base;
    logic [15:0]       idx;
    logic [15:0]       walk_last;
    logic [31:0]       timer;

    wire [ADDR_W-1:0] next_base = se_ok ? {frm_addr[ADDR_W-1:12], 12'h000} :
                                  (be_ok ? {frm_addr[ADDR_W-1:16], 16'h0000} : {frm_addr[ADDR_W-1:8], 8'h00});
    wire [31:0] start_time = start_pp ? 32'(PP_CYCLES) : (se_ok ? 32'(SE_CYCLES) : 32'(BE_CYCLES));
    wire [ADDR_W-1:0] walk_addr = ADDR_W'(base + {5'h00, idx});
    wire              walk_wr   = (state == ST_WALK) & (!is_prog | wr_mask[idx[7:0]]);
    // programming only clears bits; erase writes ones
    wire [7:0]        walk_data = is_prog ? (mem[walk_addr] & page_buf[idx[7:0]]) : ERASED_BYTE;
    wire              timer_end = (timer == 32'h0);

    // engine sequencing
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state     <= ST_IDLE;
            is_prog   <= 1'b0;
            base      <= '0;
            idx       <= 16'h0000;
            walk_last <= 16'h0000;
            timer     <= 32'h0;
            tog_seen  <= 1'b0;
        end else begin
            if (cs_rise) begin
                tog_seen <= tog_s2;
            end
            if (!timer_end) begin
                timer <= 32'(timer - 32'h1);
            end
            case (state)
                ST_IDLE: begin
                    if (start_pp | start_er) begin
                        state     <= ST_WALK;
                        is_prog   <= start_pp;
                        base      <= next_base;
                        idx       <= 16'h0000;
                        walk_last <= start_pp ? PAGE_LAST : (se_ok ? SECTOR_LAST : BLOCK_LAST);
                        timer     <= start_time;
                    end
                end
                ST_WALK: begin
                    idx <= 16'(idx + 16'h1);
                    if (idx == walk_last) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (timer_end) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // array update, one byte a cycle
    always_ff @(posedge CLOCK) begin
        if (walk_wr) begin
            mem[walk_addr] <= walk_data;
        end
    end

    // status flag and write-enable latch
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            CYCLE_IN_PROGRESS_FLAG <= 1'b0;
            WRITE_ENABLE_LATCH     <= 1'b0;
        end else begin
            // flag covers the whole timed cycle
            CYCLE_IN_PROGRESS_FLAG <= (state != ST_IDLE) ? !((state == ST_WAIT) & timer_end) : (start_pp | start_er);
            // latch drops as the cycle begins
            if (start_pp | start_er) begin
                WRITE_ENABLE_LATCH <= 1'b0;
            end else if (frame_done & cmd_write_enable_cmd & !CYCLE_IN_PROGRESS_FLAG) begin
                WRITE_ENABLE_LATCH <= 1'b1;
            end
        end
    end

endmodule : sfrpe_top

// [sfrpe_top_asserts.sv]
// port checker for the serial flash instruction engine
// assumes it is bound into sfrpe_top and sees only that module's ports
`timescale 1ns/1ps
module sfrpe_top_asserts (
    // clocks and reset
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic SCLK,
    // link
    input wire logic CS_N,
    input wire logic DIO_OUT,
    input wire logic DIO_OE_N,
    input wire logic DO_OUT,
    input wire logic DO_OE_N,
    // status
    input wire logic CYCLE_IN_PROGRESS_FLAG,
    input wire logic WRITE_ENABLE_LATCH
);
    logic [5:0]  rises;
    logic [16:0] busy_len;

    // rising edges of the current frame; select high clears it as the device does
    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            rises <= 6'h00;
        end else if (rises != 6'h3F) begin
            rises <= rises + 6'h01;
        end
    end

    // busy length, saturating so a block erase cannot wrap it
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET || !CYCLE_IN_PROGRESS_FLAG) begin
            busy_len <= 17'h00000;
        end else if (busy_len != 17'h1FFFF) begin
            busy_len <= busy_len + 17'h00001;
        end
    end

    sequence s_cycle_start;
        $rose(CYCLE_IN_PROGRESS_FLAG);
    endsequence
    sequence s_cycle_end;
        $fell(CYCLE_IN_PROGRESS_FLAG);
    endsequence

    a_deselect_release: assert property (
        @(posedge CLOCK) disable iff (RESET) CS_N |-> DO_OE_N && DIO_OE_N && !DO_OUT && !DIO_OUT)
        else $error("link driven while deselected");
    a_dual_pairs: assert property (
        @(posedge CLOCK) disable iff (RESET) !DIO_OE_N |-> !DO_OE_N)
        else $error("second line driven alone");
    a_busy_refuse: assert property (
        @(negedge SCLK) disable iff (RESET) CYCLE_IN_PROGRESS_FLAG |-> DO_OE_N && DIO_OE_N)
        else $error("read answered while busy");
    a_first_output: assert property (
        @(posedge SCLK) disable iff (RESET || CS_N) $fell(DO_OE_N) |-> rises == 6'h28 || rises == 6'h18)
        else $error("first data bit at wrong clock");
    a_dual_start: assert property (
        @(posedge SCLK) disable iff (RESET || CS_N) $fell(DIO_OE_N) |-> $fell(DO_OE_N))
        else $error("dual lines not started together");
    a_cycle_after_select: assert property (
        @(posedge CLOCK) disable iff (RESET) s_cycle_start |-> CS_N && $past(CS_N, 2))
        else $error("cycle started without select rise");
    a_latch_cleared: assert property (
        @(posedge CLOCK) disable iff (RESET) s_cycle_start |-> ##[0:2] !WRITE_ENABLE_LATCH)
        else $error("latch not cleared at cycle start");
    a_latch_at_end: assert property (
        @(posedge CLOCK) disable iff (RESET) s_cycle_end |-> !WRITE_ENABLE_LATCH)
        else $error("latch set at cycle end");
    a_latch_rise: assert property (
        @(posedge CLOCK) disable iff (RESET)
        $rose(WRITE_ENABLE_LATCH) |-> !CYCLE_IN_PROGRESS_FLAG && CS_N && $past(CS_N, 2))
        else $error("latch set outside a command end");
    a_cycle_length: assert property (
        @(posedge CLOCK) disable iff (RESET) s_cycle_end |-> busy_len >= 17'd256)
        else $error("cycle shorter than its walk");
endmodule : sfrpe_top_asserts

bind sfrpe_top sfrpe_top_asserts i_asserts (.CLOCK, .RESET, .SCLK, .CS_N, .DIO_OUT, .DIO_OE_N, .DO_OUT,
    .DO_OE_N, .CYCLE_IN_PROGRESS_FLAG, .WRITE_ENABLE_LATCH);

// [sfrpe_host.sv]
// host controller model: makes select, serial clock and data in mode 0
// assumes the device drives its lines only while its enables are low
`timescale 1ns/1ps
module sfrpe_host (
    // toward the device
    output logic      sclk,
    output logic      cs_n,
    output wire logic dio_in,
    output wire logic do_in,
    // from the device
    input wire logic  dio_out,
    input wire logic  dio_oe_n,
    input wire logic  do_out,
    input wire logic  do_oe_n
);
    logic h_dio, h_do, h_dio_en, h_do_en, idle_pat, seen_drive;

    // wire levels; an undriven line toggles so a stale level never reads as data
    assign dio_in = !dio_oe_n ? dio_out : (h_dio_en ? h_dio : idle_pat);
    assign do_in  = !do_oe_n ? do_out : (h_do_en ? h_do : idle_pat);

    initial begin
        {sclk, h_dio, h_do, h_do_en, idle_pat, seen_drive} = 6'h00;
        {cs_n, h_dio_en} = 2'h3;
    end
    always #5 idle_pat = ~idle_pat;

    // one clock; the serial clock stands low outside frames
    task automatic tick();
        #3 sclk = 1'b1;
        #3 sclk = 1'b0;
    endtask : tick

    // mode 0 single, 1 dual output, 2 dual i/o; write data left-justified
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int mode, input int nadr,
                         input int nwr, input logic [31:0] wr, input int extra, input int nrd,
                         output logic [31:0] rd);
        int i;
        rd = 32'h0;
        seen_drive = 1'b0;
        // select held low for the whole frame
        cs_n = 1'b0;
        #2;
        // opcode msb first on the input line
        for (i = 7; i >= 0; i--) begin
            h_dio = op[i];
            tick();
        end
        // dual i/o address in pairs, odd bit on the output line
        h_do_en = (mode == 2);
        for (i = nadr * (mode == 2 ? 11 : 23); nadr > 0 && i >= 0; i--) begin
            {h_do, h_dio} = mode == 2 ? {a[2*i+1], a[2*i]} : {1'b0, a[i]};
            tick();
        end
        for (i = 0; i < nwr * 8 + extra; i++) begin
            h_dio = wr[31];
            wr = wr << 1;
            tick();
        end
        if (nrd > 0) begin
            // lines released before the dummy clocks, except the input line in mode 0
            h_dio_en = (mode == 0);
            h_do_en = 1'b0;
            repeat (mode == 2 ? 4 : 8) tick();
            for (i = 0; i < nrd * (mode == 0 ? 8 : 4); i++) begin
                #3;
                seen_drive = seen_drive | !do_oe_n | !dio_oe_n;
                rd = mode == 0 ? {rd[30:0], do_out} : {rd[29:0], do_out, dio_out};
                tick();
            end
        end
        // select may rise anywhere in the data phase
        #2 cs_n = 1'b1;
        {h_dio_en, h_do_en} = 2'h2;
        #1;
    endtask : frame
endmodule : sfrpe_host

// [sfrpe_tb_top.sv]
// self-checking bench for the serial flash instruction engine
// assumes sfrpe_host makes the link and the checker is bound in
`timescale 1ns/1ps
module sfrpe_tb_top
    import sfrpe_pkg::*;
();
    localparam logic [7:0] OPC_WE = 8'h06;
    localparam logic [7:0] OPC_PW = 8'h02;
    localparam logic [7:0] OPC_SC = 8'h20;
    localparam logic [7:0] OPC_BC = 8'hD8;
    logic clock, reset;
    logic [2:0] protect_field;
    logic [31:0] rd;
    wire logic sclk, cs_n, dio_in, do_in, dio_out, dio_oe_n, do_out, do_oe_n, flag, write_enable_latch;
    int n_mismatch, compares, cycles;

    // short cycle figures; the walks bound the erase busy time, the 300-cycle timer the program
    sfrpe_top #(.OP_WRITE_ENABLE(OPC_WE), .OP_PAGE_WRITE(OPC_PW), .OP_SECTOR_CLEAR(OPC_SC),
                .OP_BLOCK_CLEAR(OPC_BC), .PP_CYCLES(300), .SE_CYCLES(10), .BE_CYCLES(10)) i_sfrpe_top (
        .CLOCK(clock), .RESET(reset), .SCLK(sclk), .CS_N(cs_n), .DIO_IN(dio_in), .DIO_OUT(dio_out),
        .DIO_OE_N(dio_oe_n), .DO_IN(do_in), .DO_OUT(do_out), .DO_OE_N(do_oe_n),
        .PROTECT_FIELD(protect_field), .CYCLE_IN_PROGRESS_FLAG(flag), .WRITE_ENABLE_LATCH(write_enable_latch));
    sfrpe_host i_sfrpe_host (.sclk(sclk), .cs_n(cs_n), .dio_in(dio_in), .do_in(do_in), .dio_out(dio_out),
        .dio_oe_n(dio_oe_n), .do_out(do_out), .do_oe_n(do_oe_n));

    initial clock = 1'b0;
    always #2 clock = ~clock;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // command frame, then flag and latch once the core has seen select rise
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nadr, input int nwr,
                       input logic [31:0] wr, input int extra, input logic [1:0] exp_fw);
        i_sfrpe_host.frame(op, a, 0, nadr, nwr, wr, extra, 0, rd);
        repeat (6) @(negedge clock);
        check("flag and latch", {30'h0, exp_fw}, {30'h0, flag, write_enable_latch});
    endtask : cmd

    task automatic wait_idle(input int limit);
        for (int k = 0; k < limit && flag !== 1'b0; k++) @(negedge clock);
        check("cycle end", 32'h0, {31'h0, flag});
    endtask : wait_idle

    task automatic rdchk(input logic [7:0] op, input int mode, input logic [23:0] a, input int n,
                         input logic [31:0] exp);
        i_sfrpe_host.frame(op, a, mode, 1, 0, 32'h0, 0, n, rd);
        check("read data", exp, rd);
        check("released", 32'h3, {30'h0, do_oe_n, dio_oe_n});
        repeat (6) @(negedge clock);
    endtask : rdchk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // hang guard; the block erase walk dominates the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        {reset, protect_field, n_mismatch, compares, cycles} = {1'b1, 3'h0, 96'h0};
        repeat (16) @(negedge clock);
        check("reset state", 32'hC, {28'h0, do_oe_n, dio_oe_n, flag, write_enable_latch});
        reset = 1'b0;
        repeat (4) @(negedge clock);
        cmd(OPC_SC, 24'h000010, 1, 0, 32'h0, 0, 2'h0);
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_SC, 24'h000010, 1, 0, 32'h0, 0, 2'h2);
        i_sfrpe_host.frame(OP_FAST_READ, 24'h0, 0, 1, 0, 32'h0, 0, 1, rd);
        check("busy drive", 32'h1, {31'h0, ~i_sfrpe_host.seen_drive & flag});
        wait_idle(4200);
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_BC, 24'hFF1234, 1, 0, 32'h0, 0, 2'h2);
        wait_idle(66000);
        $display("test done: erase");
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_PW, 24'h0000FE, 1, 3, 32'hA53C1200, 0, 2'h2);
        wait_idle(400);
        rdchk(OP_FAST_READ, 0, 24'h1FFFFF, 2, {ERASED_BYTE, 8'h12});
        rdchk(OP_DUAL_OUT, 1, 24'hE000FE, 3, {8'hA5, 8'h3C, ERASED_BYTE});
        rdchk(OP_DUAL_IO, 2, 24'h000000, 2, {8'h12, ERASED_BYTE});
        $display("test done: program and read");
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_PW, 24'h000000, 1, 1, 32'h30000000, 3, 2'h1);
        cmd(OPC_PW, 24'h000000, 1, 1, 32'h30000000, 0, 2'h2);
        wait_idle(400);
        rdchk(OP_FAST_READ, 0, 24'h000000, 1, 32'h10);
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_PW, 24'h000200, 1, 257, 32'hA5C35A00, 0, 2'h2);
        wait_idle(400);
        rdchk(OP_FAST_READ, 0, 24'h000200, 2, {16'h0, 8'h00, 8'hC3});
        $display("test done: boundary");
        protect_field = 3'h1;
        repeat (4) @(negedge clock);
        cmd(OPC_WE, 24'h0, 0, 0, 32'h0, 0, 2'h1);
        cmd(OPC_SC, 24'h1F0000, 1, 0, 32'h0, 0, 2'h1);
        cmd(OPC_BC, 24'h1F8000, 1, 0, 32'h0, 0, 2'h1);
        cmd(OPC_PW, 24'h1FFF00, 1, 1, 32'h0, 0, 2'h1);
        rdchk(OP_FAST_READ, 0, 24'h1FFF00, 1, {24'h0, ERASED_BYTE});
        protect_field = 3'h0;
        $display("test done: protection");
        report_and_stop();
    end
endmodule : sfrpe_tb_top
